// ===== design/eeprom_flash_access_ctrl.sv
// register-driven access controller for data EEPROM and program flash
// What this block does
// - 8-bit data, 256-byte data address space
// - unimplemented data write turns charge pump off
// - program word 14 bits, address 12 bits
// - 4K-word flash; higher addresses wrap
// - byte data access; word read, single-word write
// - data byte write erases location first
// - internal timer times every write/erase
// - protection keeps CPU access; per-block write lock
// - protection blocks external programmer, not CPU
// - address high bits 7:5 unimplemented; unreachable bit 4 is kept
// - space select bit 7, clear at reset
// - start bits set-only, hardware clears
// - write permit bit 2 gates writes
// - reset mid-write sets abort flag, keeps regs
// - write done flag set, software clears
// - unlock register stores nothing, reads zero
// - data read result ready next cycle
`timescale 1ns/1ps
module eeprom_flash_access_ctrl
#(
    parameter int WRITE_CYCLES = nvm_access_pkg::WRITE_CYCLES_DEF,
    parameter int DATA_DEPTH   = nvm_access_pkg::DATA_DEPTH,
    parameter int PROT_BLOCKS  = 4
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   abortReset,
    input  wire logic                   codeProtect,
    input  wire logic [PROT_BLOCKS-1:0] blockWriteLock,
    input  wire logic                   progAccessReq,
    output logic                        progAccessGrant,
    output logic                        chargePumpOn,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    localparam int PAW = nvm_access_pkg::PROG_AW;
    localparam int DAW = $clog2(DATA_DEPTH);

    logic [7:0]  dataMem [DATA_DEPTH];
    logic [13:0] progMem [nvm_access_pkg::PROG_DEPTH];

    logic [7:0]  dataLow_q, dataHigh_q, addrLow_q, addrHigh_q;
    logic        space_q, rowErase_q, permit_q, abort_q, readStart_q, writeStart_q;
    logic        done_q;
    logic [1:0]  unlock_q;
    logic        pump_q;
    nvm_access_pkg::nvm_state_e state_q;

    logic        awHeld_q, wHeld_q;
    nvm_access_pkg::bus_write_s wr_q;
    logic        bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;

    logic        abortSync1_q, abortSync2_q;

    logic        timerStart, timerDone, wrFire;
    logic [PAW-1:0] progAddr;
    logic [DAW-1:0] dataAddr;
    logic        dataUnimpl, blockLocked;

    // decode an offset to a byte-wide register hit
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // external reset request synchroniser
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            abortSync1_q <= 1'b0;
            abortSync2_q <= 1'b0;
        end
        else
        begin
            abortSync1_q <= abortReset;
            abortSync2_q <= abortSync1_q;
        end
    end

    // address forms for each space
    assign progAddr   = {addrHigh_q[3:0], addrLow_q};
    assign dataAddr   = addrLow_q[DAW-1:0];
    assign dataUnimpl = (int'(addrLow_q) >= DATA_DEPTH);
    assign blockLocked = codeProtect
        && blockWriteLock[progAddr[PAW-1 -: $clog2(PROT_BLOCKS)]];
    assign progAccessGrant = progAccessReq && !codeProtect;

    // bus write channel capture
    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    assign wrFire = awHeld_q && wHeld_q && !bvalid_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            wr_q     <= '0;
            bvalid_q <= 1'b0;
            bresp_q  <= nvm_access_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q   <= 1'b1;
                wr_q.addr  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q    <= 1'b1;
                wr_q.data  <= s_axi_wdata[7:0];
                wr_q.strb  <= s_axi_wstrb;
            end
            if (wrFire)
            begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (wr_q.addr > nvm_access_pkg::OFF_FLAGS_TWO || wr_q.addr[1:0] != 2'h0)
                            ? nvm_access_pkg::RESP_SLVERR : nvm_access_pkg::RESP_OKAY;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    logic wrCtl, wrUnl, wrByte;
    assign wrByte = wrFire && wr_q.strb[0];
    assign wrCtl  = wrByte && hit(wr_q.addr, nvm_access_pkg::OFF_CONTROL);
    assign wrUnl  = wrByte && hit(wr_q.addr, nvm_access_pkg::OFF_UNLOCK);

    // unlock sequence tracker
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            unlock_q <= 2'h0;
        end
        else if (wrUnl)
        begin
            if (wr_q.data == nvm_access_pkg::UNLOCK_KEY_ONE)
                unlock_q <= 2'h1;
            else if (wr_q.data == nvm_access_pkg::UNLOCK_KEY_TWO && unlock_q == 2'h1)
                unlock_q <= 2'h2;
            else
                unlock_q <= 2'h0;
        end
        else if (wrByte)
        begin
            unlock_q <= 2'h0;
        end
    end

    logic reqRead, reqWrite;
    assign reqRead  = wrCtl && wr_q.data[nvm_access_pkg::BIT_READ_START]
                      && state_q == nvm_access_pkg::ST_IDLE;
    assign reqWrite = wrCtl && wr_q.data[nvm_access_pkg::BIT_WRITE_START]
                      && state_q == nvm_access_pkg::ST_IDLE && unlock_q == 2'h2
                      && (permit_q || wr_q.data[nvm_access_pkg::BIT_PERMIT]) && !reqRead;
    assign timerStart = reqWrite;

    // sequencing of read, write and erase cycles
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_q <= nvm_access_pkg::ST_IDLE;
        else if (abortSync2_q)
            state_q <= nvm_access_pkg::ST_IDLE;
        else
        begin
            unique case (state_q)
                nvm_access_pkg::ST_IDLE:  state_q <= reqRead ? nvm_access_pkg::ST_READ
                    : !reqWrite ? state_q
                    : (space_q && rowErase_q) ? nvm_access_pkg::ST_ERASE : nvm_access_pkg::ST_WRITE;
                nvm_access_pkg::ST_READ: state_q <= nvm_access_pkg::ST_IDLE;
                nvm_access_pkg::ST_WRITE, nvm_access_pkg::ST_ERASE:
                    state_q <= timerDone ? nvm_access_pkg::ST_IDLE : state_q;
            endcase
        end
    end

    // control register, software and hardware owned fields
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            space_q      <= 1'b0;
            rowErase_q   <= 1'b0;
            permit_q     <= 1'b0;
            abort_q      <= 1'b0;
            readStart_q  <= 1'b0;
            writeStart_q <= 1'b0;
        end
        else
        begin
            if (wrCtl)
            begin
                space_q    <= wr_q.data[nvm_access_pkg::BIT_SPACE];
                rowErase_q <= wr_q.data[nvm_access_pkg::BIT_ROW_ERASE];
                permit_q   <= wr_q.data[nvm_access_pkg::BIT_PERMIT];
                abort_q    <= wr_q.data[nvm_access_pkg::BIT_ABORT];
            end
            if (abortSync2_q && writeStart_q)
                abort_q <= 1'b1;
            readStart_q  <= reqRead;
            if (reqWrite)
                writeStart_q <= 1'b1;
            else if (timerDone || abortSync2_q)
                writeStart_q <= 1'b0;
        end
    end

    // holding registers, memory read loads and charge pump
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dataLow_q  <= nvm_access_pkg::DATA_RESET;
            dataHigh_q <= nvm_access_pkg::DATA_RESET;
            addrLow_q  <= nvm_access_pkg::ADDR_RESET;
            addrHigh_q <= nvm_access_pkg::ADDR_RESET;
            pump_q     <= 1'b0;
        end
        else
        begin
            if (wrByte && hit(wr_q.addr, nvm_access_pkg::OFF_DATA_LOW))  dataLow_q  <= wr_q.data;
            if (wrByte && hit(wr_q.addr, nvm_access_pkg::OFF_DATA_HIGH)) dataHigh_q <= {2'h0, wr_q.data[5:0]};
            if (wrByte && hit(wr_q.addr, nvm_access_pkg::OFF_ADDR_LOW))  addrLow_q  <= wr_q.data;
            if (wrByte && hit(wr_q.addr, nvm_access_pkg::OFF_ADDR_HIGH)) addrHigh_q <= {3'h0, wr_q.data[4:0]};
            if (readStart_q)
            begin
                if (space_q)
                begin
                    dataLow_q  <= progMem[progAddr][7:0];
                    dataHigh_q <= {2'h0, progMem[progAddr][13:8]};
                end
                else
                    dataLow_q <= dataMem[dataAddr];
            end
            if (reqWrite)
                pump_q <= space_q ? !blockLocked : !dataUnimpl;
            else if (timerDone || abortSync2_q)
                pump_q <= 1'b0;
        end
    end

    // array contents change only when the timed cycle completes
    always_ff @(posedge sys_clk)
    begin
        if (timerDone && pump_q && !abortSync2_q)
        begin
            if (!space_q)
                dataMem[dataAddr] <= dataLow_q;
            else if (state_q == nvm_access_pkg::ST_ERASE)
            begin
                for (int i = 0; i < nvm_access_pkg::ROW_WORDS; i++)
                    progMem[{progAddr[PAW-1:5], 5'(i)}] <= '1;
            end
            else
            begin
                for (int i = 0; i < nvm_access_pkg::BLOCK_WORDS; i++)
                    if (2'(i) == progAddr[1:0])
                        progMem[{progAddr[PAW-1:2], 2'(i)}] <= {dataHigh_q[5:0], dataLow_q};
            end
        end
    end

    // write done flag: set wins over clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            done_q <= 1'b0;
        else if (timerDone)
            done_q <= 1'b1;
        else if (wrByte && hit(wr_q.addr, nvm_access_pkg::OFF_FLAGS_TWO)
                 && !wr_q.data[nvm_access_pkg::BIT_WRITE_DONE])
            done_q <= 1'b0;
    end

    nvm_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer
    (
        .sys_clk (sys_clk),
        .rst     (rst || abortSync2_q),
        .start   (timerStart),
        .done    (timerDone)
    );

    // bus read channel
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= nvm_access_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= nvm_access_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                nvm_access_pkg::OFF_CONTROL:   rdata_q <= {24'h0, space_q, 2'h0, rowErase_q,
                                                           abort_q, permit_q, writeStart_q, readStart_q};
                nvm_access_pkg::OFF_UNLOCK:    rdata_q <= '0;
                nvm_access_pkg::OFF_DATA_LOW:  rdata_q <= {24'h0, dataLow_q};
                nvm_access_pkg::OFF_DATA_HIGH: rdata_q <= {24'h0, dataHigh_q};
                nvm_access_pkg::OFF_ADDR_LOW:  rdata_q <= {24'h0, addrLow_q};
                nvm_access_pkg::OFF_ADDR_HIGH: rdata_q <= {24'h0, addrHigh_q};
                nvm_access_pkg::OFF_FLAGS_TWO: rdata_q <= {27'h0, done_q, 4'h0};
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= nvm_access_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign chargePumpOn  = pump_q;
endmodule

// ===== design/nvm_access_pkg.sv
// shared constants and types for the nonvolatile memory access controller
package nvm_access_pkg;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_UNLOCK    = 8'h04;
    localparam logic [7:0] OFF_DATA_LOW  = 8'h08;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h0C;
    localparam logic [7:0] OFF_ADDR_LOW  = 8'h10;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h14;
    localparam logic [7:0] OFF_FLAGS_TWO = 8'h18;

    // control register field positions
    localparam int BIT_READ_START  = 0;
    localparam int BIT_WRITE_START = 1;
    localparam int BIT_PERMIT      = 2;
    localparam int BIT_ABORT       = 3;
    localparam int BIT_ROW_ERASE   = 4;
    localparam int BIT_SPACE       = 7;
    // flag register field position
    localparam int BIT_WRITE_DONE  = 4;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [7:0] ADDR_RESET    = 8'h00;

    // unlock sequence keys
    localparam logic [7:0] UNLOCK_KEY_ONE = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_TWO = 8'hAA;

    // memory geometry
    localparam int DATA_DEPTH  = 256;
    localparam int PROG_DEPTH  = 4096;
    localparam int PROG_AW     = 12;
    localparam int WORD_W      = 14;
    localparam int BLOCK_WORDS = 4;
    localparam int ROW_WORDS   = 32;

    // write cycle timing
    localparam int CLK_MHZ          = 250;
    localparam int WRITE_TIME_US    = 4;
    localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_ERASE = 4'b1000
    } nvm_state_e;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] data;
        logic [3:0] strb;
    } bus_write_s;

endpackage

// ===== design/nvm_write_timer.sv
// countdown timer that paces write and erase cycles
`timescale 1ns/1ps
module nvm_write_timer
#(
    parameter int CYCLES = 1000
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count_q;
    logic          run_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= '0;
            run_q   <= 1'b0;
        end
        else if (start)
        begin
            count_q <= CW'(CYCLES - 1);
            run_q   <= 1'b1;
        end
        else if (run_q)
        begin
            if (count_q == '0)
            begin
                run_q <= 1'b0;
            end
            else
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    assign done = run_q && (count_q == '0);
endmodule

// ===== sim/eeprom_flash_access_ctrl_bench.sv
// self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
module eeprom_flash_access_ctrl_bench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        abortReset = 1'b0;
    logic        codeProtect = 1'b0;
    logic [3:0]  blockWriteLock = 4'h0;
    logic        progAccessReq = 1'b0;
    logic        progAccessGrant;
    logic        chargePumpOn;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] v;
    int          mismatches = 0;
    int          cmp_count = 0;

    eeprom_flash_access_ctrl #(.WRITE_CYCLES(40), .DATA_DEPTH(128), .PROT_BLOCKS(4)) dut_u
    (
        .sys_clk(sys_clk), .rst(rst), .abortReset(abortReset), .codeProtect(codeProtect),
        .blockWriteLock(blockWriteLock), .progAccessReq(progAccessReq),
        .progAccessGrant(progAccessGrant), .chargePumpOn(chargePumpOn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    always #2 sys_clk = ~sys_clk;

    task automatic close_out();
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (tb !== 1'b1)
        begin
            @(negedge sys_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge sys_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tv;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tv = 1'b0;
        while (tv !== 1'b1)
        begin
            @(negedge sys_clk);
            ta = arvalid && arready;
            tv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
            if (ta)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdv(input logic [7:0] a);
        logic [1:0] r;
        rd(a, v, r);
    endtask

    task automatic arm(input logic [7:0] ctl);
        wr(nvm_access_pkg::OFF_UNLOCK, nvm_access_pkg::UNLOCK_KEY_ONE);
        wr(nvm_access_pkg::OFF_UNLOCK, nvm_access_pkg::UNLOCK_KEY_TWO);
        wr(nvm_access_pkg::OFF_CONTROL, ctl);
    endtask

    task automatic wait_idle();
        int n = 0;
        v = 32'h2;
        while (v[1] !== 1'b0 && n < 100)
        begin
            rdv(nvm_access_pkg::OFF_CONTROL);
            n++;
        end
        check("write bit clears", v & 32'h2, 32'h0);
    endtask

    task automatic read_mem(input logic [7:0] ctl);
        logic [1:0] r;
        wr(nvm_access_pkg::OFF_CONTROL, ctl);
        rd(nvm_access_pkg::OFF_DATA_LOW, lo, r);
        rd(nvm_access_pkg::OFF_DATA_HIGH, hi, r);
    endtask

    task automatic test_reset();
        logic [1:0] r;
        rdv(nvm_access_pkg::OFF_CONTROL);
        check("control reset", v, 32'h0);
        wr(nvm_access_pkg::OFF_UNLOCK, 8'h5A);
        rdv(nvm_access_pkg::OFF_UNLOCK);
        check("unlock reads zero", v, 32'h0);
        rd(8'h40, v, r);
        check("unmapped resp", {30'h0, r}, {30'h0, nvm_access_pkg::RESP_SLVERR});
        progAccessReq <= 1'b1;
        @(negedge sys_clk);
        check("grant open", {31'h0, progAccessGrant}, 32'h1);
        @(posedge sys_clk) codeProtect <= 1'b1;
        @(negedge sys_clk);
        check("grant blocked", {31'h0, progAccessGrant}, 32'h0);
        @(posedge sys_clk) codeProtect <= 1'b0;
    endtask

    task automatic test_data();
        wr(nvm_access_pkg::OFF_ADDR_LOW, 8'h5A);
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h3C);
        arm(8'h06);
        rdv(nvm_access_pkg::OFF_CONTROL);
        check("write bit set", v & 32'h2, 32'h2);
        check("pump on", {31'h0, chargePumpOn}, 32'h1);
        wait_idle();
        rdv(nvm_access_pkg::OFF_FLAGS_TWO);
        check("done flag set", v & 32'h10, 32'h10);
        wr(nvm_access_pkg::OFF_FLAGS_TWO, 8'h10);
        rdv(nvm_access_pkg::OFF_FLAGS_TWO);
        check("done flag kept", v & 32'h10, 32'h10);
        wr(nvm_access_pkg::OFF_FLAGS_TWO, 8'h00);
        rdv(nvm_access_pkg::OFF_FLAGS_TWO);
        check("done flag cleared", v & 32'h10, 32'h0);
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'hC3);
        arm(8'h06);
        wait_idle();
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h00);
        read_mem(8'h01);
        check("byte rewritten", lo, 32'hC3);
    endtask

    task automatic test_refused();
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h11);
        wr(nvm_access_pkg::OFF_CONTROL, 8'h06);
        wr(nvm_access_pkg::OFF_UNLOCK, nvm_access_pkg::UNLOCK_KEY_ONE);
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h11);
        wr(nvm_access_pkg::OFF_UNLOCK, nvm_access_pkg::UNLOCK_KEY_TWO);
        wr(nvm_access_pkg::OFF_CONTROL, 8'h06);
        check("broken unlock", {31'h0, chargePumpOn}, 32'h0);
        wr(nvm_access_pkg::OFF_CONTROL, 8'h00);
        arm(8'h02);
        rdv(nvm_access_pkg::OFF_CONTROL);
        check("no permit", v & 32'h2, 32'h0);
        read_mem(8'h01);
        check("byte unchanged", lo, 32'hC3);
        wr(nvm_access_pkg::OFF_ADDR_LOW, 8'h90);
        arm(8'h06);
        check("unimplemented pump", {31'h0, chargePumpOn}, 32'h0);
        wait_idle();
    endtask

    task automatic test_prog();
        wr(nvm_access_pkg::OFF_ADDR_HIGH, 8'h13);
        wr(nvm_access_pkg::OFF_ADDR_LOW, 8'h20);
        wr(nvm_access_pkg::OFF_CONTROL, 8'h94);
        arm(8'h96);
        wait_idle();
        wr(nvm_access_pkg::OFF_CONTROL, 8'h84);
        wr(nvm_access_pkg::OFF_ADDR_LOW, 8'h21);
        wr(nvm_access_pkg::OFF_DATA_HIGH, 8'h2A);
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h5B);
        arm(8'h86);
        wait_idle();
        wr(nvm_access_pkg::OFF_ADDR_HIGH, 8'h03);
        read_mem(8'h81);
        check("word low", lo, 32'h5B);
        check("word high", hi, 32'h2A);
        wr(nvm_access_pkg::OFF_ADDR_LOW, 8'h22);
        read_mem(8'h81);
        check("erased low", lo, 32'hFF);
        check("erased high", hi, 32'h3F);
    endtask

    task automatic test_protect();
        codeProtect <= 1'b1;
        blockWriteLock <= 4'h1;
        wr(nvm_access_pkg::OFF_ADDR_LOW, 8'h21);
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h66);
        wr(nvm_access_pkg::OFF_CONTROL, 8'h84);
        arm(8'h86);
        check("locked pump", {31'h0, chargePumpOn}, 32'h0);
        wait_idle();
        read_mem(8'h81);
        check("locked word", lo, 32'h5B);
        wr(nvm_access_pkg::OFF_ADDR_LOW, 8'h5A);
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h77);
        wr(nvm_access_pkg::OFF_CONTROL, 8'h04);
        arm(8'h06);
        wait_idle();
        read_mem(8'h01);
        check("protected data", lo, 32'h77);
        codeProtect <= 1'b0;
    endtask

    task automatic test_busy_abort();
        wr(nvm_access_pkg::OFF_DATA_LOW, 8'h44);
        arm(8'h06);
        wr(nvm_access_pkg::OFF_CONTROL, 8'h05);
        rdv(nvm_access_pkg::OFF_CONTROL);
        check("busy start bits", v & 32'h3, 32'h2);
        abortReset <= 1'b1;
        repeat (6) @(posedge sys_clk);
        abortReset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("abort pump", {31'h0, chargePumpOn}, 32'h0);
        rdv(nvm_access_pkg::OFF_CONTROL);
        check("abort flag", v & 32'hA, 32'h8);
        rdv(nvm_access_pkg::OFF_DATA_LOW);
        check("abort data kept", v, 32'h44);
        rdv(nvm_access_pkg::OFF_ADDR_LOW);
        check("abort addr kept", v, 32'h5A);
    endtask

    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_data();
        test_refused();
        test_prog();
        test_protect();
        test_busy_abort();
        close_out();
    end

    initial
    begin
        #200000;
        mismatches++;
        close_out();
    end
endmodule

// ===== sim/nvm_access_asserts.sv
// port-level checks on the nonvolatile access controller
`timescale 1ns/1ps
module nvm_access_asserts
#(
    parameter int WRITE_CYCLES = 8
)
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        abortReset,
    input wire logic        codeProtect,
    input wire logic        progAccessReq,
    input wire logic        progAccessGrant,
    input wire logic        chargePumpOn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid
);
    localparam int PUMP_MAX = WRITE_CYCLES + 6;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence unlock_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == nvm_access_pkg::OFF_UNLOCK;
    endsequence
    sequence pump_start;
        $rose(chargePumpOn) && !abortReset;
    endsequence
    grant_gate_a: assert property (progAccessGrant == (progAccessReq && !codeProtect))
        else $error("programmer grant wrong");
    write_answer_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    unlock_zero_a: assert property (unlock_read |=> s_axi_rdata == 32'h0)
        else $error("unlock register not zero");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    pump_min_a: assert property (pump_start |-> chargePumpOn[*3])
        else $error("pump dropped early");
    pump_max_a: assert property ($rose(chargePumpOn) |-> ##[1:PUMP_MAX] !chargePumpOn)
        else $error("pump stuck on");
    abort_stop_a: assert property ($rose(abortReset) |-> ##[1:4] !chargePumpOn)
        else $error("abort did not stop pump");
endmodule

bind eeprom_flash_access_ctrl nvm_access_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u
(
    .sys_clk(sys_clk), .rst(rst), .abortReset(abortReset), .codeProtect(codeProtect),
    .progAccessReq(progAccessReq), .progAccessGrant(progAccessGrant),
    .chargePumpOn(chargePumpOn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid)
);
